/* File: design/sfd_decision.sv */
// Functional notes
// - total snr is log2 of energy over background
// - average total snr over recent frames
// - per-band log snr floored, then averaged
// - first long-term snr is log10 energy ratio
// - adjusted long-term snr uses centroid term
// - clipped centroid term between 1.4 and 2.2
// - blend background centroid on active updating frames
// - initial lf snr from two accumulators
// - smooth lf snr with 0.9 and 0.1
// - clamp 0.12 times (lf minus 3)
// - tonal frame flag starts cleared each frame
// - tonal tests gated by tonality levels
// - tonal frame needs stability, centroid, flatness
// - tonal level rises or decays per frame
// - tonal level starts inside zero to one
// - tonal signal when level above one half
// - stability, centroid, tonality mark non-noise
// - low flatness marks non-noise
// - energy jump marks non-noise; smooth energy
// - high tonality marks non-noise
// - quiet stable frames force background update
// - background update flag is one bit
// - accumulate background energy when updating, non-tonal
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module sfd_decision (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire logic i_frame_valid,
	input wire sfd_pkg::sfd_feat_type i_feat,
	output logic o_result_valid,
	output sfd_pkg::sfd_result_type o_result
);
	// ----------------------------------------
	// arithmetic helpers
	// ----------------------------------------
	function automatic logic signed [31:0] sfd_log2(input logic [31:0] x);
		logic [4:0] p;
		logic [31:0] n;
		p = '0;
		n = '0;
		for (int i = 0; i < 32; i++) begin
			if (x[i]) begin
				p = 5'(i);
			end
		end
		n = x << (5'd31 - p);
		// linear mantissa: cheap, error under 0.09 of one octave
		if (x == '0) begin
			return sfd_pkg::LOG_FLOOR;
		end
		return {16'(int'(p) - sfd_pkg::FRAC), n[30:15]};
	endfunction : sfd_log2

	function automatic logic signed [31:0] sfd_qmul(
		input logic signed [31:0] a,
		input logic signed [31:0] b
	);
		logic signed [63:0] p;
		p = 64'(a) * 64'(b);
		return p[47:16];
	endfunction : sfd_qmul

	function automatic logic [31:0] sfd_umul(
		input logic [31:0] a,
		input logic [31:0] b
	);
		logic [63:0] p;
		p = {32'h0000_0000, a} * {32'h0000_0000, b};
		return p[47:16];
	endfunction : sfd_umul

	function automatic logic signed [31:0] sfd_mean(
		input logic signed [31:0] acc,
		input logic [15:0] cnt
	);
		logic signed [31:0] q;
		q = '0;
		if (cnt != '0) begin
			q = acc / $signed({16'h0000, cnt});
		end
		return q;
	endfunction : sfd_mean

	// ----------------------------------------
	// state and frame datapath
	// ----------------------------------------
	sfd_pkg::sfd_state_type st_r;
	sfd_pkg::sfd_state_type st_nxt;
	logic take;
	logic [31:0] ebg_prev;
	logic signed [31:0] tot;
	logic signed [35:0] hsum;
	logic signed [31:0] tband;
	logic signed [35:0] fsum;
	logic signed [31:0] fsnr;
	logic signed [31:0] first_lt;
	logic signed [31:0] ctc;
	logic signed [31:0] lf_l;
	logic signed [31:0] tlf;
	logic signed [31:0] lf_c;
	logic ton_gate;
	logic tf;
	logic signed [31:0] lvl;
	logic sig;
	logic non_noise;
	logic ovr;
	logic upd;
	logic setup;
	logic access;

	assign take = i_frame_valid & st_r.enable;
	assign setup = i_psel & ~i_penable;
	assign access = i_psel & i_penable;
	assign o_pready = access;
	assign o_prdata = st_r.prdata;
	assign o_pslverr = st_r.pslverr & access;
	assign o_result_valid = st_r.res_valid;
	assign o_result = st_r.res;

	always_comb begin
		st_nxt = st_r;
		st_nxt.res_valid = 1'b0;
		// previous-frame background average
		ebg_prev = 32'(st_r.bg_sum / {24'h00_0000, st_r.bg_cnt});
		tot = sfd_log2(i_feat.energy + sfd_pkg::EPS)
			- sfd_log2(ebg_prev);
		hsum = 36'(tot);
		for (int i = 0; i < sfd_pkg::NHIST; i++) begin
			if (st_r.hptr != i[sfd_pkg::NHIST_SHIFT-1:0]) begin
				hsum = hsum + 36'($signed(st_r.hist[i]));
			end
		end
		fsum = '0;
		tband = '0;
		for (int i = 0; i < sfd_pkg::NSUB; i++) begin
			tband = sfd_log2(i_feat.sub_energy[i] + sfd_pkg::EPS)
				- sfd_log2(i_feat.bg_sub_energy[i] + sfd_pkg::EPS);
			if (tband < sfd_pkg::SUB_FLOOR) begin
				tband = '0;
			end
			fsum = fsum + 36'(tband);
		end
		fsnr = 32'(fsum >>> sfd_pkg::NSUB_SHIFT);
		first_lt = sfd_qmul(sfd_log2(i_feat.lt_active)
			- sfd_log2(i_feat.lt_inactive), sfd_pkg::LOG10_OF_2);
		if (st_r.centroid_lt < sfd_pkg::CEN_LO) begin
			ctc = '0;
		end else if (st_r.centroid_lt <= sfd_pkg::CEN_HI) begin
			ctc = st_r.centroid_lt - sfd_pkg::CEN_LO;
		end else begin
			ctc = sfd_pkg::CEN_TOP;
		end
		lf_l = sfd_mean(i_feat.sp_acc, i_feat.sp_cnt)
			- sfd_mean(i_feat.ns_acc, i_feat.ns_cnt);
		tlf = sfd_qmul(sfd_pkg::K_0P12, lf_l - sfd_pkg::K_3);
		if (tlf < 0) begin
			lf_c = '0;
		end else if (tlf > st_r.lf_ceil) begin
			lf_c = st_r.lf_ceil;
		end else begin
			lf_c = tlf;
		end
		// tonal evaluation
		tf = 1'b0;
		ton_gate = (i_feat.tonality_raw > sfd_pkg::TON_RAW_GATE)
			| (i_feat.tonality_sm1 > sfd_pkg::TON_SM_GATE);
		if (ton_gate) begin
			tf = (i_feat.stability5 < sfd_pkg::TS5_TONAL)
				& (i_feat.centroid0 > sfd_pkg::SC0_TONAL)
				& (($signed(i_feat.flatness[0]) < sfd_pkg::FL0_TONAL)
				| ($signed(i_feat.flatness[1]) < sfd_pkg::FL1_TONAL)
				| ($signed(i_feat.flatness[2]) < sfd_pkg::FL2_TONAL));
		end
		if (tf) begin
			lvl = sfd_qmul(sfd_pkg::LVL_DECAY_ON, st_r.tonal_level)
				+ sfd_pkg::LVL_STEP;
		end else begin
			lvl = sfd_qmul(sfd_pkg::LVL_DECAY_OFF, st_r.tonal_level);
		end
		sig = lvl > sfd_pkg::HALF;
		// background update decision
		non_noise = (i_feat.stability5 > sfd_pkg::TS5_NOISE)
			| ((i_feat.centroid0 > sfd_pkg::SC0_NOISE)
			& (i_feat.stability5 > sfd_pkg::TS5_SC_NOISE))
			| ((i_feat.tonality_sm1 > sfd_pkg::HALF)
			& (i_feat.stability5 > sfd_pkg::TS5_TON_NOISE));
		non_noise = non_noise
			| ($signed(i_feat.flatness[0]) < sfd_pkg::FL0_NOISE)
			| ($signed(i_feat.flatness[1]) < sfd_pkg::FL1_NOISE)
			| ($signed(i_feat.flatness[2]) < sfd_pkg::FL2_NOISE);
		non_noise = non_noise | ({5'b0_0000, i_feat.energy}
			> ({5'b0_0000, st_r.sf_energy} << sfd_pkg::BIG_SHIFT));
		non_noise = non_noise
			| (i_feat.tonality_sm1 > sfd_pkg::TON_RAW_GATE)
			| (i_feat.tonality_raw > sfd_pkg::TON_SM_GATE);
		ovr = (fsnr < sfd_pkg::FSNR_OVR) & (tot < sfd_pkg::TSNR_OVR)
			& (i_feat.tonality_sm1 < sfd_pkg::HALF)
			& (i_feat.stability3 < sfd_pkg::TS3_OVR)
			& ~i_feat.combined_activity_flag & ~sig;
		upd = ~non_noise | ovr;
		if (take) begin
			st_nxt.hist[st_r.hptr] = tot;
			st_nxt.hptr = st_r.hptr + 1'b1;
			st_nxt.res.total_snr = tot;
			st_nxt.res.avg_total_snr =
				32'(hsum >>> sfd_pkg::NHIST_SHIFT);
			st_nxt.res.freq_snr = fsnr;
			st_nxt.res.first_longterm_snr = first_lt;
			st_nxt.res.adj_longterm_snr = first_lt + sfd_qmul(sfd_qmul(
				sfd_pkg::K_0P4, sfd_qmul(sfd_pkg::K_0P4, first_lt)
				+ sfd_pkg::K_0P1), ctc);
			st_nxt.res.lf_snr_initial = lf_l;
			st_nxt.lf_smooth = sfd_qmul(sfd_pkg::K_0P9, st_r.lf_smooth)
				+ sfd_qmul(sfd_pkg::K_0P1, lf_l);
			st_nxt.res.lf_snr_smoothed = st_nxt.lf_smooth;
			st_nxt.res.lf_snr_clamped = lf_c;
			st_nxt.tonal_level = lvl;
			st_nxt.res.tonal_level = lvl;
			st_nxt.res.tonal_frame_flag = tf;
			st_nxt.res.tonal_signal_flag = sig;
			st_nxt.res.bg_update_flag = upd;
			st_nxt.sf_energy = sfd_umul(sfd_pkg::ESF_KEEP, st_r.sf_energy)
				+ sfd_umul(sfd_pkg::ESF_TAKE, i_feat.energy);
			if (i_feat.frame_active & upd) begin
				st_nxt.centroid_lt = $signed(sfd_umul(st_r.alpha,
					st_r.centroid_lt)) + $signed(sfd_umul(
					32'(sfd_pkg::Q_ONE) - st_r.alpha,
					i_feat.centroid0));
			end
			// counter saturates so the average never divides by zero
			if (upd & ~sig & (st_r.bg_cnt != '1)) begin
				st_nxt.bg_sum = st_r.bg_sum + {8'h00, i_feat.energy};
				st_nxt.bg_cnt = st_r.bg_cnt + 1'b1;
			end
			st_nxt.frames = st_r.frames + 1'b1;
			st_nxt.res_valid = 1'b1;
		end
		// ----------------------------------------
		// apb slave
		// ----------------------------------------
		if (setup) begin
			st_nxt.pslverr = 1'b0;
			unique case (i_paddr)
			sfd_pkg::A_CTRL: st_nxt.prdata = {31'h0, st_r.enable};
			sfd_pkg::A_LF_CEIL: st_nxt.prdata = st_r.lf_ceil;
			sfd_pkg::A_ALPHA: st_nxt.prdata = st_r.alpha;
			sfd_pkg::A_STATUS: st_nxt.prdata = {29'h0,
				st_r.res.bg_update_flag, st_r.res.tonal_signal_flag,
				st_r.res.tonal_frame_flag};
			sfd_pkg::A_TONAL: st_nxt.prdata = st_r.tonal_level;
			sfd_pkg::A_LT_SNR: st_nxt.prdata = st_r.res.adj_longterm_snr;
			sfd_pkg::A_FREQ: st_nxt.prdata = st_r.res.freq_snr;
			sfd_pkg::A_FRAMES: st_nxt.prdata = st_r.frames;
			default: begin
				st_nxt.prdata = '0;
				st_nxt.pslverr = 1'b1;
			end
			endcase
		end
		if (access & i_pwrite) begin
			if (i_paddr == sfd_pkg::A_CTRL) begin
				st_nxt.enable = i_pwdata[0];
			end
			if (i_paddr == sfd_pkg::A_LF_CEIL) begin
				st_nxt.lf_ceil = i_pwdata;
			end
			// alpha kept inside (0,1): zero or one would copy or freeze
			if (i_paddr == sfd_pkg::A_ALPHA && i_pwdata != '0
				&& i_pwdata < 32'(sfd_pkg::Q_ONE)) begin
				st_nxt.alpha = i_pwdata;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= '0;
			st_r.bg_sum <= sfd_pkg::BG_SUM_INIT;
			st_r.bg_cnt <= sfd_pkg::BG_CNT_INIT;
			st_r.tonal_level <= sfd_pkg::TONAL_INIT;
			st_r.enable <= 1'b1;
			st_r.lf_ceil <= sfd_pkg::CEIL_INIT;
			st_r.alpha <= sfd_pkg::ALPHA_INIT;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	a_result_strobe: assert property (take |=> o_result_valid)
		else $error("result strobe missing after frame");
	a_no_spurious: assert property (!take |=> !o_result_valid)
		else $error("result strobe without frame");
	a_signal_level: assert property (o_result_valid |->
		o_result.tonal_signal_flag == (o_result.tonal_level > sfd_pkg::HALF))
		else $error("tonal signal disagrees with level");
	a_tonal_gated: assert property (o_result_valid
		&& o_result.tonal_frame_flag |-> $past(ton_gate))
		else $error("tonal frame without gate");
	a_level_range: assert property (o_result_valid |->
		o_result.tonal_level >= 0 && o_result.tonal_level <= sfd_pkg::Q_ONE)
		else $error("tonal level out of range");
	a_lf_clamp: assert property (o_result_valid |->
		o_result.lf_snr_clamped >= 0
		&& o_result.lf_snr_clamped <= $past(st_r.lf_ceil))
		else $error("lf snr outside clamp");
	a_freq_floor: assert property (o_result_valid |->
		o_result.freq_snr >= sfd_pkg::SUB_FLOOR)
		else $error("freq snr below floor");
	a_centroid_term: assert property (ctc >= 0
		&& ctc <= sfd_pkg::CEN_TOP)
		else $error("centroid term out of range");
	a_bg_count: assert property (take && upd && !sig
		&& st_r.bg_cnt != '1 |=> st_r.bg_cnt == $past(st_r.bg_cnt) + 1'b1)
		else $error("background count not advanced");
	a_bg_hold: assert property (take && !(upd && !sig) |=>
		$stable(st_r.bg_cnt) && $stable(st_r.bg_sum))
		else $error("background sum moved");
	a_override: assert property (take && ovr |=>
		o_result.bg_update_flag)
		else $error("override did not force update");
	a_centroid_hold: assert property (take
		&& !(i_feat.frame_active && upd) |=> $stable(st_r.centroid_lt))
		else $error("centroid changed without update");

	// ----------------------------------------
	// decision cross-checks
	// ----------------------------------------
	// the override outranks every non-noise test, so those are
	// checked only on frames that leave the override off
	a_noise_stab: assert property (take && !ovr
		&& i_feat.stability5 > sfd_pkg::TS5_NOISE
		|=> !o_result.bg_update_flag)
		else $error("unstable frame kept as noise");
	a_noise_flat: assert property (take && !ovr
		&& $signed(i_feat.flatness[1]) < sfd_pkg::FL1_NOISE
		|=> !o_result.bg_update_flag)
		else $error("flat spectrum test ignored");
	a_energy_jump: assert property (take && !ovr
		&& {5'b0_0000, i_feat.energy}
		> ({5'b0_0000, st_r.sf_energy} << sfd_pkg::BIG_SHIFT)
		|=> !o_result.bg_update_flag)
		else $error("energy jump kept as noise");
	a_tonal_noise: assert property (take && !ovr
		&& i_feat.tonality_raw > sfd_pkg::TON_SM_GATE
		|=> !o_result.bg_update_flag)
		else $error("tonal frame kept as noise");
	a_tonal_clear: assert property (take && !ton_gate
		|=> !o_result.tonal_frame_flag)
		else $error("tonal frame flag not cleared");
	a_level_decay: assert property (take && !tf
		|=> o_result.tonal_level <= $past(st_r.tonal_level))
		else $error("tonal level rose on plain frame");
	a_level_rise: assert property (take && tf
		&& st_r.tonal_level < sfd_pkg::HALF
		|=> o_result.tonal_level > $past(st_r.tonal_level))
		else $error("tonal level did not rise");
	a_frame_count: assert property (take
		|=> st_r.frames == $past(st_r.frames) + 1'b1)
		else $error("frame count not advanced");
	a_refused: assert property (i_frame_valid && !st_r.enable
		|=> $stable(st_r.tonal_level) && $stable(st_r.bg_cnt))
		else $error("refused frame changed state");
	a_alpha_range: assert property (st_r.alpha != '0
		&& st_r.alpha < 32'(sfd_pkg::Q_ONE))
		else $error("blend weight left the open range");
endmodule : sfd_decision

/* File: design/sfd_pkg.sv */
package sfd_pkg;
	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NSUB = 4;
	localparam int NSUB_SHIFT = 2;
	localparam int NHIST = 8;
	localparam int NHIST_SHIFT = 3;
	localparam int FRAC = 16;
	localparam int BIG_SHIFT = 5;

	// ----------------------------------------
	// q16.16 constants
	// ----------------------------------------
	localparam logic signed [31:0] Q_ONE = 32'h0001_0000;
	localparam logic signed [31:0] LOG_FLOOR = 32'hfff0_0000;
	localparam logic signed [31:0] LOG10_OF_2 = 32'h0000_4d10;
	localparam logic [31:0] EPS = 32'h0000_0007;
	localparam logic signed [31:0] SUB_FLOOR = 32'hffff_e666;
	localparam logic signed [31:0] K_0P4 = 32'h0000_6666;
	localparam logic signed [31:0] K_0P1 = 32'h0000_199a;
	localparam logic signed [31:0] CEN_LO = 32'h0001_6666;
	localparam logic signed [31:0] CEN_HI = 32'h0002_3333;
	localparam logic signed [31:0] CEN_TOP = 32'h0000_cccd;
	localparam logic signed [31:0] K_0P9 = 32'h0000_e666;
	localparam logic signed [31:0] K_3 = 32'h0003_0000;
	localparam logic signed [31:0] K_0P12 = 32'h0000_1eb8;
	localparam logic signed [31:0] TON_RAW_GATE = 32'h0000_999a;
	localparam logic signed [31:0] TON_SM_GATE = 32'h0000_dc29;
	localparam logic signed [31:0] TS5_TONAL = 32'h0000_126f;
	localparam logic signed [31:0] SC0_TONAL = 32'h0001_3333;
	localparam logic signed [31:0] FL0_TONAL = 32'h0000_c28f;
	localparam logic signed [31:0] FL1_TONAL = 32'h0000_e148;
	localparam logic signed [31:0] FL2_TONAL = 32'h0000_f5c3;
	localparam logic signed [31:0] LVL_DECAY_ON = 32'h0000_f99a;
	localparam logic signed [31:0] LVL_STEP = 32'h0000_0666;
	localparam logic signed [31:0] LVL_DECAY_OFF = 32'h0000_ff3b;
	localparam logic signed [31:0] HALF = 32'h0000_8000;
	localparam logic signed [31:0] TS5_NOISE = 32'h0000_1eb8;
	localparam logic signed [31:0] SC0_NOISE = 32'h0004_0000;
	localparam logic signed [31:0] TS5_SC_NOISE = 32'h0000_0a3d;
	localparam logic signed [31:0] TS5_TON_NOISE = 32'h0000_199a;
	localparam logic signed [31:0] FL0_NOISE = 32'h0000_cccd;
	localparam logic signed [31:0] FL1_NOISE = 32'h0000_c7ae;
	localparam logic signed [31:0] FL2_NOISE = 32'h0000_cccd;
	localparam logic [31:0] ESF_KEEP = 32'h0000_f333;
	localparam logic [31:0] ESF_TAKE = 32'h0000_0ccd;
	localparam logic signed [31:0] FSNR_OVR = 32'h0000_4ccd;
	localparam logic signed [31:0] TSNR_OVR = 32'h0001_3333;
	localparam logic signed [31:0] TS3_OVR = 32'h0000_199a;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic signed [31:0] TONAL_INIT = 32'h0000_0000;
	localparam logic [39:0] BG_SUM_INIT = 40'h00_0001_0000;
	localparam logic [15:0] BG_CNT_INIT = 16'h0001;
	localparam logic signed [31:0] CEIL_INIT = 32'h0002_8000;
	localparam logic [31:0] ALPHA_INIT = 32'h0000_e666;

	// ----------------------------------------
	// apb map
	// ----------------------------------------
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_LF_CEIL = 12'h004;
	localparam logic [11:0] A_ALPHA = 12'h008;
	localparam logic [11:0] A_STATUS = 12'h00c;
	localparam logic [11:0] A_TONAL = 12'h010;
	localparam logic [11:0] A_LT_SNR = 12'h014;
	localparam logic [11:0] A_FREQ = 12'h018;
	localparam logic [11:0] A_FRAMES = 12'h01c;

	typedef struct packed {
		logic [31:0] energy;
		logic [NSUB-1:0][31:0] sub_energy;
		logic [NSUB-1:0][31:0] bg_sub_energy;
		logic [31:0] lt_active;
		logic [31:0] lt_inactive;
		logic signed [31:0] sp_acc;
		logic [15:0] sp_cnt;
		logic signed [31:0] ns_acc;
		logic [15:0] ns_cnt;
		logic signed [31:0] tonality_raw;
		logic signed [31:0] tonality_sm1;
		logic signed [31:0] stability3;
		logic signed [31:0] stability5;
		logic signed [31:0] centroid0;
		logic [2:0][31:0] flatness;
		logic combined_activity_flag;
		logic frame_active;
	} sfd_feat_type;

	typedef struct packed {
		logic signed [31:0] total_snr;
		logic signed [31:0] avg_total_snr;
		logic signed [31:0] freq_snr;
		logic signed [31:0] first_longterm_snr;
		logic signed [31:0] adj_longterm_snr;
		logic signed [31:0] lf_snr_initial;
		logic signed [31:0] lf_snr_smoothed;
		logic signed [31:0] lf_snr_clamped;
		logic signed [31:0] tonal_level;
		logic tonal_frame_flag;
		logic tonal_signal_flag;
		logic bg_update_flag;
	} sfd_result_type;

	typedef struct packed {
		logic [NHIST-1:0][31:0] hist;
		logic [NHIST_SHIFT-1:0] hptr;
		logic [39:0] bg_sum;
		logic [15:0] bg_cnt;
		logic signed [31:0] centroid_lt;
		logic signed [31:0] lf_smooth;
		logic signed [31:0] tonal_level;
		logic [31:0] sf_energy;
		logic enable;
		logic signed [31:0] lf_ceil;
		logic [31:0] alpha;
		logic [31:0] frames;
		sfd_result_type res;
		logic res_valid;
		logic [31:0] prdata;
		logic pslverr;
	} sfd_state_type;
endpackage : sfd_pkg

/* File: testbench/sfd_feature_source.sv */
`timescale 1ns/1ps
// --------------------
// upstream feature extractor model
// --------------------
module sfd_feature_source (
	input wire logic i_clk,
	output logic o_frame_valid,
	output sfd_pkg::sfd_feat_type o_feat
);
	initial begin
		o_frame_valid = 1'b0;
		o_feat = '0;
	end

	// bus is scrambled outside the strobe: stale sampling cannot pass
	task automatic send(input sfd_pkg::sfd_feat_type f);
		@(posedge i_clk);
		o_frame_valid <= 1'b1;
		o_feat <= f;
		@(posedge i_clk);
		o_frame_valid <= 1'b0;
		o_feat <= ~f;
	endtask : send
endmodule : sfd_feature_source

/* File: testbench/test_sfd_decision.sv */
`timescale 1ns/1ps
module test_sfd_decision;
	logic i_clk;
	logic i_reset_n;
	logic psel;
	logic pen;
	logic pwr;
	logic [11:0] pa;
	logic [31:0] pwd;
	logic [31:0] rd;
	logic err;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic fv;
	logic rv;
	sfd_pkg::sfd_feat_type feat;
	sfd_pkg::sfd_feat_type f;
	sfd_pkg::sfd_result_type r;
	int failures;
	int tests_run;
	real lvl;

	sfd_decision dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
		.o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
		.i_frame_valid(fv), .i_feat(feat), .o_result_valid(rv),
		.o_result(r));
	sfd_feature_source src (.i_clk(i_clk), .o_frame_valid(fv),
		.o_feat(feat));

	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	// --------------------
	// helpers
	// --------------------
	function automatic logic [31:0] q(input real v);
		return $rtoi(v * 65536.0);
	endfunction : q

	task automatic give_verdict();
		if (failures == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	task automatic ck_bit(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %b seen %b", n, e, g);
		end
	endtask : ck_bit

	task automatic ck_word(input string n, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : ck_word

	// fixed point log is approximate, so figures are compared in a band
	task automatic ck_near(input string n, input real e,
		input logic [31:0] g, input real t);
		real s;
		s = $itor($signed(g)) / 65536.0;
		tests_run++;
		if ($isunknown(g) || s > e + t || s < e - t) begin
			failures++;
			$display("wrong value %s expected %f seen %f", n, e, s);
		end
	endtask : ck_near

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge i_clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge i_clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic frame(input logic t);
		src.send(f);
		#1;
		ck_bit("result_valid", t, rv);
	endtask : frame

	task automatic base();
		f = '0;
		f.energy = q(1.0);
		f.sub_energy = {4{q(1.0)}};
		f.bg_sub_energy = {4{q(1.0)}};
		f.lt_active = q(1.0);
		f.lt_inactive = q(1.0);
		f.sp_cnt = 16'h0001;
		f.ns_cnt = 16'h0001;
		f.tonality_raw = q(0.1);
		f.tonality_sm1 = q(0.1);
		f.stability3 = q(0.03);
		f.stability5 = q(0.03);
		f.centroid0 = q(1.0);
		f.flatness = {3{q(0.99)}};
	endtask : base

	// --------------------
	// scenarios
	// --------------------
	task automatic t_regs();
		logic [11:0] a[4];
		logic [31:0] e[4];
		a = '{sfd_pkg::A_CTRL, sfd_pkg::A_LF_CEIL, sfd_pkg::A_ALPHA,
			sfd_pkg::A_TONAL};
		e = '{32'h0000_0001, 32'h0002_8000, 32'h0000_e666, 32'h0};
		apb(1'b1, sfd_pkg::A_TONAL, 32'h0000_4000);
		apb(1'b1, sfd_pkg::A_ALPHA, 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, a[i], 32'h0);
			ck_word("register", e[i], rd);
			ck_bit("pslverr", 1'b0, err);
		end
		apb(1'b0, 12'h020, 32'h0);
		ck_bit("pslverr", 1'b1, err);
		ck_word("prdata", 32'h0, rd);
		apb(1'b1, sfd_pkg::A_CTRL, 32'h0);
		base();
		frame(1'b0);
		apb(1'b1, sfd_pkg::A_CTRL, 32'h1);
		frame(1'b1);
	endtask : t_regs

	task automatic t_bg();
		for (int k = 0; k < 11; k++) begin
			base();
			f.combined_activity_flag = 1'b1;
			case (k)
				0: f.stability5 = q(0.13);
				1: begin
					f.centroid0 = q(4.1);
					f.stability5 = q(0.05);
				end
				2: begin
					f.tonality_sm1 = q(0.55);
					f.stability5 = q(0.11);
				end
				3: f.flatness[0] = q(0.79);
				4: f.flatness[1] = q(0.77);
				5: f.flatness[2] = q(0.79);
				6: f.tonality_sm1 = q(0.61);
				7: f.tonality_raw = q(0.87);
				8: f.stability5 = q(0.11);
				10: f.energy = q(40.0);
				default: begin
					f.centroid0 = q(4.1);
					f.stability5 = q(0.035);
				end
			endcase
			frame(1'b1);
			ck_bit("bg_update", k == 8 || k == 9, r.bg_update_flag);
		end
		base();
		f.flatness[0] = q(0.79);
		frame(1'b1);
		ck_bit("bg_update", 1'b1, r.bg_update_flag);
		f.stability3 = q(0.2);
		frame(1'b1);
		ck_bit("bg_update", 1'b0, r.bg_update_flag);
	endtask : t_bg

	task automatic t_tonal();
		logic e;
		lvl = 0.0;
		for (int k = 0; k < 200; k++) begin
			base();
			f.tonality_raw = q(0.7);
			f.stability5 = q(0.05);
			f.centroid0 = q(1.3);
			f.flatness[0] = q(0.75);
			e = 1'b1;
			case (k)
				0: begin
					f.tonality_raw = q(0.5);
					f.tonality_sm1 = q(0.87);
				end
				1: begin
					f.tonality_raw = q(0.5);
					e = 1'b0;
				end
				2: begin
					f.stability5 = q(0.08);
					e = 1'b0;
				end
				3: begin
					f.centroid0 = q(1.1);
					e = 1'b0;
				end
				4: f.flatness = {q(0.99), q(0.87), q(0.99)};
				5: f.flatness = {q(0.95), q(0.99), q(0.99)};
				6: begin
					f.flatness[0] = q(0.99);
					e = 1'b0;
				end
				default: begin
					if (k >= 48) begin
						f.tonality_raw = q(0.1);
						e = 1'b0;
					end
				end
			endcase
			frame(1'b1);
			if (e) begin
				lvl = 0.975 * lvl + 0.025;
			end else begin
				lvl = 0.997 * lvl;
			end
			ck_bit("tonal_frame", e, r.tonal_frame_flag);
			ck_near("tonal_level", lvl, r.tonal_level, 0.005);
			if (lvl > 0.51 || lvl < 0.49) begin
				ck_bit("tonal_signal", lvl > 0.51, r.tonal_signal_flag);
			end
		end
	endtask : t_tonal

	task automatic t_snr();
		base();
		f.combined_activity_flag = 1'b1;
		f.flatness[0] = q(0.79);
		f.energy = q(4.0);
		f.sub_energy = {q(1.0), q(2.0), q(0.5), q(4.0)};
		for (int k = 1; k <= 8; k++) begin
			frame(1'b1);
			ck_near("total_snr", 2.0, r.total_snr, 0.1);
			if (k == 4) begin
				ck_near("avg_total_snr", 1.0, r.avg_total_snr, 0.1);
			end
		end
		ck_near("avg_total_snr", 2.0, r.avg_total_snr, 0.1);
		ck_near("freq_snr", 0.75, r.freq_snr, 0.1);
	endtask : t_snr

	task automatic t_lt();
		real t;
		t = 10.0 * 0.30103;
		apb(1'b1, sfd_pkg::A_ALPHA, 32'h0000_0001);
		base();
		f.lt_active = q(1024.0);
		f.frame_active = 1'b1;
		f.centroid0 = q(3.0);
		repeat (2) frame(1'b1);
		ck_near("first_lt", t, r.first_longterm_snr, 0.05);
		ck_near("adj_lt", t + 0.32 * (0.4 * t + 0.1),
			r.adj_longterm_snr, 0.05);
		f.centroid0 = q(1.8);
		repeat (2) frame(1'b1);
		ck_near("adj_lt", t + 0.16 * (0.4 * t + 0.1),
			r.adj_longterm_snr, 0.05);
		f.frame_active = 1'b0;
		f.centroid0 = q(1.0);
		repeat (2) frame(1'b1);
		ck_near("adj_lt", t + 0.16 * (0.4 * t + 0.1),
			r.adj_longterm_snr, 0.05);
		f.frame_active = 1'b1;
		repeat (2) frame(1'b1);
		ck_near("adj_lt", t, r.adj_longterm_snr, 0.05);
	endtask : t_lt

	task automatic t_lf();
		base();
		f.sp_acc = q(8.0);
		f.ns_acc = q(1.0);
		repeat (60) frame(1'b1);
		ck_near("lf_initial", 7.0, r.lf_snr_initial, 0.01);
		ck_near("lf_smoothed", 7.0, r.lf_snr_smoothed, 0.05);
		ck_near("lf_clamped", 0.48, r.lf_snr_clamped, 0.01);
		f.sp_acc = q(10.0);
		f.sp_cnt = 16'h0002;
		frame(1'b1);
		ck_near("lf_initial", 4.0, r.lf_snr_initial, 0.01);
		ck_near("lf_smoothed", 6.7, r.lf_snr_smoothed, 0.05);
		f.sp_acc = q(80.0);
		frame(1'b1);
		ck_near("lf_clamped", 2.5, r.lf_snr_clamped, 0.01);
		apb(1'b1, sfd_pkg::A_LF_CEIL, q(1.0));
		frame(1'b1);
		ck_near("lf_clamped", 1.0, r.lf_snr_clamped, 0.01);
		f.sp_acc = q(2.0);
		frame(1'b1);
		ck_near("lf_clamped", 0.0, r.lf_snr_clamped, 0.01);
		apb(1'b0, sfd_pkg::A_FRAMES, 32'h0);
		ck_word("frames", 32'h0000_0126, rd);
		apb(1'b0, sfd_pkg::A_STATUS, 32'h0);
		ck_word("status", 32'h0000_0004, rd);
	endtask : t_lf

	initial begin
		failures = 0;
		tests_run = 0;
		i_reset_n = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		pa = '0;
		pwd = '0;
		f = '0;
		repeat (10) @(posedge i_clk);
		i_reset_n <= 1'b1;
		t_regs();
		t_bg();
		t_tonal();
		t_snr();
		t_lt();
		t_lf();
		give_verdict();
	end
endmodule : test_sfd_decision
